//--- hdl/run_seq.sv
// Run-mode sequencer for one waveform or pulse channel, with APB registers.
// Assumes trigger pins are asynchronous and a playback engine that reports cycle ends.
`timescale 1ns/1ps
`include "run_seq_regs.svh"

// What this block does
// - Trigger source selects front input, backplane line 0-7, software or two timers.
// - Internal timer fires repeatedly at a programmed interval up to 20 s.
// - Re-trigger delay runs from end of one output to next start, 20 ns steps.
// - Re-trigger operation needs one trigger then self-triggers after each delay.
// - Exactly one of continuous, triggered, gated, burst modes is active.
// - Continuous mode plays at once and repeats with no trigger.
// - Continuous play ends only on output off, armed bit cleared or mode change.
// - Triggered mode detects rising or falling edge per slope setting.
// - Each trigger plays one cycle, then holds the first sample.
// - Level gate enables output only while trigger level is asserted.
// - Edge gate toggles open and closed on qualifying transitions.
// - Closing gate finishes the current cycle, then holds a DC level.
// - Burst mode plays a programmed cycle count per trigger, then idles.
// - Burst uses the same trigger sources as triggered mode.
// - One shared input serves as trigger and gate, read per run mode.
// - Pulse unit routes separate trigger and gate inputs to an assigned channel.
// - Modulated idle option one plays unmodulated output while idle.
// - Modulated idle option two holds DC while idle.
module run_seq
  import run_seq_pkg::*;
#(
  parameter int BURST_W = 32,
  parameter int TIME_W  = 32
) (
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire apb_req_t   apb_req_i,
  output apb_rsp_t        apb_rsp_o,
  input  wire logic       front_trigger_input_i,
  input  wire logic       gate_input_i,
  input  wire logic [7:0] bp_trig_i,
  input  wire logic       cycle_end_i,
  output play_cmd_t       play_o,
  output logic            running_o
);

  initial begin
    if (BURST_W < 1 || BURST_W > 32 || TIME_W < 8 || TIME_W > 32) begin
      $error("run_seq: unsupported width");
    end
  end

  // Two-flop synchronisers on every trigger pin
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic [9:0] sync3_q;
  always_ff @(posedge core_clk_i) begin
    sync1_q <= {gate_input_i, front_trigger_input_i, bp_trig_i};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  // Registers
  logic [31:0]       ctrl_q;
  logic [BURST_W-1:0] burst_q;
  logic [TIME_W-1:0]  period_q;
  logic [TIME_W-1:0]  delay_q;
  logic              sw_trig_q;
  logic              pready_q;
  logic [31:0]       prdata_q;

  // Field decode
  wire run_mode_t mode      = run_mode_t'(ctrl_q[`RS_CTRL_MODE_LO +: 2]);
  wire            gate_edge = ctrl_q[`RS_CTRL_GEDGE];
  wire            slope_neg = ctrl_q[`RS_CTRL_SLOPE];
  wire [3:0]      src       = ctrl_q[`RS_CTRL_SRC_LO +: 4];
  wire            retrig_en = ctrl_q[`RS_CTRL_RETRIG];
  wire            out_on    = ctrl_q[`RS_CTRL_OUT_ON];
  wire            mod_on    = ctrl_q[`RS_CTRL_MOD_ON];
  wire            idle_dc   = ctrl_q[`RS_CTRL_IDLE_DC];
  wire            in_sel    = ctrl_q[`RS_CTRL_INSEL];
  wire            armed     = ctrl_q[`RS_CTRL_ARMED];

  // Shared input picks the front pin; a pulse unit may route its own gate pin instead
  wire [9:0] s_now  = sync2_q;
  wire [9:0] s_prev = sync3_q;
  wire       use_gate_pin = in_sel && (mode == MODE_GATE);
  wire       ext_idx_hi   = use_gate_pin;
  wire       front_now    = ext_idx_hi ? s_now[9] : s_now[8];
  wire       front_prev   = ext_idx_hi ? s_prev[9] : s_prev[8];

  // Source select, level and edge
  function automatic logic pick(input logic [9:0] v, input logic [3:0] s, input logic hi);
    logic r;
    r = 1'b0;
    if (s[3] == 1'b0) begin
      r = v[s[2:0]];
    end else if (s == SRC_FRONT) begin
      r = hi ? v[9] : v[8];
    end
    return r;
  endfunction

  wire lvl_raw  = pick(s_now, src, ext_idx_hi);
  wire lvl_old  = pick(s_prev, src, ext_idx_hi);
  wire lvl      = lvl_raw ^ slope_neg;
  wire lvl_d1   = lvl_old ^ slope_neg;
  wire ext_edge = lvl && !lvl_d1;
  wire unused_front = front_now ^ front_prev;

  // Internal periodic trigger timer
  logic [TIME_W-1:0] tmr_q;
  wire [TIME_W-1:0]  period_cyc = (period_q < TIME_W'(`RS_MIN_PERIOD_CYC)) ?
                                  TIME_W'(`RS_MIN_PERIOD_CYC) : period_q;
  wire tmr_fire = (tmr_q >= period_cyc - TIME_W'(1));
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || src != SRC_TIMER) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_fire ? '0 : tmr_q + TIME_W'(1);
    end
  end

  // Re-trigger delay: programmed in 20 ns steps, counted in clock cycles
  logic [TIME_W+1:0] dly_q;
  logic              dly_run_q;
  wire [TIME_W+1:0]  dly_cyc_raw = {delay_q, 2'b00};
  wire [TIME_W+1:0]  dly_cyc = (dly_cyc_raw < (TIME_W+2)'(`RS_MIN_DELAY_CYC)) ?
                               (TIME_W+2)'(`RS_MIN_DELAY_CYC) : dly_cyc_raw;
  wire dly_done = dly_run_q && (dly_q >= dly_cyc - (TIME_W+2)'(1));
  logic retrig_armed_q;

  // Trigger event from the selected source
  wire trig_evt = (src == SRC_TIMER)  ? tmr_fire :
                  (src == SRC_SOFT)   ? sw_trig_q :
                  (src == SRC_RETRIG) ? (sw_trig_q || ext_edge) : ext_edge;
  wire auto_evt = retrig_en && retrig_armed_q && dly_done;
  wire any_trig = trig_evt || auto_evt;

  // Gate state for both gating styles
  logic gate_tgl_q;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || mode != MODE_GATE || !gate_edge) begin
      gate_tgl_q <= 1'b0;
    end else if (trig_evt) begin
      gate_tgl_q <= !gate_tgl_q;
    end
  end
  wire gate_open = gate_edge ? gate_tgl_q : lvl;

  // Sequencer
  seq_state_t        st_q;
  seq_state_t        st_d;
  logic [BURST_W-1:0] left_q;
  logic [BURST_W-1:0] left_d;
  wire cont_go = (mode == MODE_CONT) && out_on && armed;

  always_comb begin
    st_d   = st_q;
    left_d = left_q;
    case (st_q)
      ST_IDLE: begin
        if (cont_go) begin
          st_d = ST_PLAY;
        end else if (out_on && mode == MODE_GATE && gate_open) begin
          st_d = ST_PLAY;
        end else if (out_on && (mode == MODE_TRIG || mode == MODE_BURST) && any_trig) begin
          st_d   = ST_PLAY;
          left_d = (mode == MODE_BURST) ? burst_q : BURST_W'(1);
        end
      end
      ST_PLAY: begin
        if (!out_on) begin
          st_d = ST_IDLE;
        end else if (cycle_end_i) begin
          case (mode)
            MODE_CONT: st_d = ST_PLAY;
            MODE_GATE: st_d = gate_open ? ST_PLAY : ST_IDLE;
            default: begin
              if (left_q <= BURST_W'(1)) begin
                st_d = ST_IDLE;
              end else begin
                left_d = left_q - BURST_W'(1);
              end
            end
          endcase
        end else if (mode == MODE_GATE && !gate_open) begin
          st_d = ST_DRAIN;
        end else if (mode == MODE_CONT && !cont_go) begin
          st_d = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!out_on || cycle_end_i) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_q   <= ST_IDLE;
      left_q <= '0;
    end else begin
      st_q   <= st_d;
      left_q <= left_d;
    end
  end

  // Re-trigger delay counts from the end of each played signal
  wire play_end = (st_q != ST_IDLE) && (st_d == ST_IDLE);
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !retrig_en || !out_on) begin
      dly_q          <= '0;
      dly_run_q      <= 1'b0;
      retrig_armed_q <= 1'b0;
    end else begin
      if (trig_evt) begin
        retrig_armed_q <= 1'b1;
      end
      if (play_end) begin
        dly_run_q <= 1'b1;
        dly_q     <= '0;
      end else if (dly_done || st_q != ST_IDLE) begin
        dly_run_q <= 1'b0;
      end else if (dly_run_q) begin
        dly_q <= dly_q + (TIME_W+2)'(1);
      end
    end
  end

  // Engine commands, registered
  wire playing   = (st_d != ST_IDLE);
  wire start_d   = (st_q == ST_IDLE) && playing;
  wire mod_idle1 = mod_on && !idle_dc && mode != MODE_CONT && out_on;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      play_o    <= '0;
      running_o <= 1'b0;
    end else begin
      play_o.start      <= start_d;
      play_o.modulate   <= mod_on && playing && mode != MODE_CONT;
      play_o.hold_first <= !playing && !mod_on && mode == MODE_TRIG;
      play_o.hold_dc    <= !playing && !mod_idle1 &&
                           !(!mod_on && mode == MODE_TRIG);
      running_o         <= playing || mod_idle1;
    end
  end

  // APB slave, one wait state: ready in the second access cycle
  wire       setup   = apb_req_i.psel && !apb_req_i.penable;
  wire       access  = apb_req_i.psel && apb_req_i.penable && !pready_q;
  wire       wr_en   = access && apb_req_i.pwrite;
  wire [11:0] addr   = apb_req_i.paddr;
  wire       hit     = (addr == `RS_OFF_CTRL) || (addr == `RS_OFF_BURST) || (addr == `RS_OFF_PERIOD) ||
                       (addr == `RS_OFF_DELAY) || (addr == `RS_OFF_CMD) || (addr == `RS_OFF_STATUS);
  wire [31:0] status = {26'h0, retrig_armed_q, gate_open, dly_run_q, running_o, st_q};
  wire [31:0] rd_mux = (addr == `RS_OFF_CTRL)   ? ctrl_q :
                       (addr == `RS_OFF_BURST)  ? 32'(burst_q) :
                       (addr == `RS_OFF_PERIOD) ? 32'(period_q) :
                       (addr == `RS_OFF_DELAY)  ? 32'(delay_q) :
                       (addr == `RS_OFF_STATUS) ? status : 32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ctrl_q    <= `RS_CTRL_RST;
      burst_q   <= BURST_W'(`RS_BURST_RST);
      period_q  <= TIME_W'(`RS_PERIOD_RST);
      delay_q   <= TIME_W'(`RS_DELAY_RST);
      sw_trig_q <= 1'b0;
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      apb_rsp_o <= '0;
    end else begin
      sw_trig_q <= wr_en && (addr == `RS_OFF_CMD) && apb_req_i.pwdata[`RS_CMD_SWTRIG];
      pready_q  <= access;
      apb_rsp_o.pready  <= access;
      apb_rsp_o.pslverr <= access && !hit;
      apb_rsp_o.prdata  <= (access && !apb_req_i.pwrite) ? rd_mux : 32'h0000_0000;
      if (wr_en && addr == `RS_OFF_CTRL) begin
        ctrl_q <= apb_req_i.pwdata;
      end
      if (wr_en && addr == `RS_OFF_BURST) begin
        burst_q <= apb_req_i.pwdata[BURST_W-1:0];
      end
      if (wr_en && addr == `RS_OFF_PERIOD) begin
        period_q <= apb_req_i.pwdata[TIME_W-1:0];
      end
      if (wr_en && addr == `RS_OFF_DELAY) begin
        delay_q <= apb_req_i.pwdata[TIME_W-1:0];
      end
      prdata_q <= setup ? 32'h0000_0000 : prdata_q;
    end
  end

endmodule // run_seq

//--- hdl/run_seq_regs.svh
// Register map, field positions, reset values and timing constants of the run sequencer.
// Assumes a 200 MHz core clock and a 32-bit APB slave.
`ifndef RUN_SEQ_REGS_SVH
`define RUN_SEQ_REGS_SVH

`define RS_OFF_CTRL      12'h000
`define RS_OFF_BURST     12'h004
`define RS_OFF_PERIOD    12'h008
`define RS_OFF_DELAY     12'h00c
`define RS_OFF_CMD       12'h010
`define RS_OFF_STATUS    12'h014

// Control register fields
`define RS_CTRL_MODE_LO  0
`define RS_CTRL_GEDGE    2
`define RS_CTRL_SLOPE    3
`define RS_CTRL_SRC_LO   4
`define RS_CTRL_RETRIG   8
`define RS_CTRL_OUT_ON   9
`define RS_CTRL_MOD_ON   10
`define RS_CTRL_IDLE_DC  11
`define RS_CTRL_INSEL    12
`define RS_CTRL_ARMED    13
`define RS_CTRL_RST      32'h0000_0000

// Command register bits
`define RS_CMD_SWTRIG    0

// Timing: time in ns, counts derived from the 5 ns clock period
`define RS_CLK_NS        5
`define RS_STEP_NS       20
`define RS_MIN_DELAY_NS  100
`define RS_STEP_CYC      (`RS_STEP_NS / `RS_CLK_NS)
`define RS_MIN_DELAY_CYC ((`RS_MIN_DELAY_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)
`define RS_MIN_PERIOD_CYC ((`RS_MIN_DELAY_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)
`define RS_BURST_RST     32'h0000_0001
`define RS_PERIOD_RST    32'h0000_0014
`define RS_DELAY_RST     32'h0000_0005

`endif

//--- hdl/run_seq_pkg.sv
// Types shared by the run sequencer: modes, trigger sources, states and bus carriers.
// Assumes nothing beyond a SystemVerilog compiler.
package run_seq_pkg;

  typedef enum logic [1:0] {
    MODE_CONT  = 2'h0,
    MODE_TRIG  = 2'h1,
    MODE_GATE  = 2'h2,
    MODE_BURST = 2'h3
  } run_mode_t;

  // Source codes 0..7 are the backplane lines
  typedef enum logic [3:0] {
    SRC_BP0    = 4'h0,
    SRC_FRONT  = 4'h8,
    SRC_SOFT   = 4'h9,
    SRC_TIMER  = 4'ha,
    SRC_RETRIG = 4'hb
  } trig_src_t;

  // Gray along idle -> play -> drain
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PLAY  = 2'b01,
    ST_DRAIN = 2'b11,
    ST_WAIT  = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // Commands to the playback engine
  typedef struct packed {
    logic start;
    logic modulate;
    logic hold_first;
    logic hold_dc;
  } play_cmd_t;

endpackage

//--- verif/play_engine_model.sv
// Playback engine stand-in: plays fixed-length cycles and pulses each cycle end.
// Assumes play_o and running_o of the sequencer on the same clock.
`timescale 1ns/1ps
module play_engine_model
  import run_seq_pkg::*;
#(
  parameter int CYC_LEN = 8
) (
  input  wire logic      core_clk_i,
  input  wire logic      nrst_i,
  input  wire play_cmd_t play_i,
  input  wire logic      running_i,
  output logic           cycle_end_o
);
  logic [7:0] cnt_q;
  logic       act_q;
  wire        last = (cnt_q == 8'(CYC_LEN - 1));
  // A start restarts the cycle, so every cycle runs its full length
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || play_i.start || !(act_q || running_i)) cnt_q <= 8'h00;
    else cnt_q <= last ? 8'h00 : cnt_q + 8'h01;
    if (!nrst_i) act_q <= 1'b0;
    else act_q <= play_i.start | (act_q & ~(last & ~running_i));
  end
  assign cycle_end_o = last && (act_q || running_i);
endmodule // play_engine_model

//--- verif/run_seq_sva.sv
// Port checks of the run sequencer: register answers and play command shape.
// Assumes a bind onto run_seq; sees its ports only.
`timescale 1ns/1ps
module run_seq_sva
  import run_seq_pkg::*;
(
  input wire logic      core_clk_i,
  input wire logic      nrst_i,
  input wire apb_req_t  apb_req_i,
  input wire apb_rsp_t  apb_rsp_o,
  input wire play_cmd_t play_o,
  input wire logic      running_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // First access edge of a transfer
  sequence s_access;
    apb_req_i.psel && apb_req_i.penable && !$past(apb_req_i.penable);
  endsequence
  sequence s_start;
    play_o.start;
  endsequence
  a_ready_wait: assert property (s_access |=> apb_rsp_o.pready) else $error("pready late");
  a_ready_once: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready) else $error("pready too long");
  a_ready_cause: assert property (apb_rsp_o.pready |-> $past(apb_req_i.psel && apb_req_i.penable))
    else $error("pready without access");
  a_err_data: assert property (apb_rsp_o.pslverr |-> apb_rsp_o.pready && apb_rsp_o.prdata == 32'h0)
    else $error("bad error answer");
  a_start_pulse: assert property (s_start |=> !play_o.start) else $error("start too long");
  a_start_holds: assert property (s_start |=> !play_o.hold_first && !play_o.hold_dc)
    else $error("hold during play");
  a_hold_one: assert property (!(play_o.hold_first && play_o.hold_dc)) else $error("two holds");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |=> play_o == 4'h0 && !running_o)
    else $error("outputs live in reset");
endmodule // run_seq_sva

//--- verif/run_seq_bench.sv
// Self-checking bench of the run sequencer: APB tasks and mode scenarios.
// Assumes the playback engine model on the far side.
`timescale 1ns/1ps
`include "run_seq_regs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module run_seq_bench;
  import run_seq_pkg::*;
  localparam int CYC_LEN = 8;
  logic        clk      = 1'b0;
  logic        nrst     = 1'b0;
  apb_req_t    req      = '0;
  apb_rsp_t    rsp;
  logic        front    = 1'b0;
  logic        gate     = 1'b0;
  logic [7:0]  bp       = 8'h00;
  logic        cyc_end;
  play_cmd_t   play;
  logic        running;
  int          errors   = 0;
  int          n_checks = 0;
  int          n_start  = 0;
  int          n_end    = 0;
  int          n_mod    = 0;
  logic [31:0] rd;
  logic        err;
  always #2.5 clk = ~clk;
  run_seq u_run_seq (.core_clk_i(clk), .nrst_i(nrst), .apb_req_i(req), .apb_rsp_o(rsp),
    .front_trigger_input_i(front), .gate_input_i(gate), .bp_trig_i(bp), .cycle_end_i(cyc_end),
    .play_o(play), .running_o(running));
  play_engine_model #(.CYC_LEN(CYC_LEN)) u_play_engine_model (.core_clk_i(clk), .nrst_i(nrst),
    .play_i(play), .running_i(running), .cycle_end_o(cyc_end));
  // Counted on the edge, before the design's own updates land
  always @(posedge clk) begin
    if (play.start === 1'b1) n_start++;
    if (play.start === 1'b1 && play.modulate === 1'b1) n_mod++;
    if (cyc_end === 1'b1 && running === 1'b1) n_end++;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One transfer; held until pready is sampled high at a rising edge, answer taken there
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      give_verdict();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wait_starts(input int target);
    int n;
    for (n = 0; n < 2000 && n_start < target; n++) @(posedge clk);
    `CHK("start count", target, n_start)
  endtask
  task automatic wait_run(input logic lvl);
    int n;
    for (n = 0; n < 300 && running !== lvl; n++) @(posedge clk);
    `CHK("running", lvl, running)
  endtask
  function automatic logic [31:0] cfg(input run_mode_t m, input logic [3:0] s, input logic [31:0] x);
    return 32'(m) | (32'(s) << `RS_CTRL_SRC_LO) | x | (32'h1 << `RS_CTRL_OUT_ON) | (32'h1 << `RS_CTRL_ARMED);
  endfunction
  initial begin
    logic [11:0] offs [4] = '{`RS_OFF_CTRL, `RS_OFF_BURST, `RS_OFF_PERIOD, `RS_OFF_DELAY};
    logic [31:0] rsts [4] = '{`RS_CTRL_RST, `RS_BURST_RST, `RS_PERIOD_RST, `RS_DELAY_RST};
    int s;
    int n;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, then an unmapped word is refused
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, offs[i], 32'h0);
      `CHK("reset value", rsts[i], rd)
    end
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    $display("test regs done");
    // Slope choice: rising edge counts only for positive slope
    for (int sl = 0; sl < 2; sl++) begin
      apb(1'b1, `RS_OFF_CTRL, cfg(MODE_TRIG, SRC_FRONT, 32'(sl) << `RS_CTRL_SLOPE));
      s = n_start;
      front <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("rise start", (sl == 1) ? s : s + 1, n_start)
      front <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("fall start", s + 1, n_start)
      `CHK("hold first", 1'b1, play.hold_first)
    end
    // Every backplane line as source, one start per edge
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `RS_OFF_CTRL, cfg(MODE_TRIG, 4'(i), 32'h0));
      s = n_start;
      bp[i] <= 1'b1;
      wait_starts(s + 1);
      bp[i] <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("one start", s + 1, n_start)
    end
    $display("test trigger done");
    apb(1'b1, `RS_OFF_BURST, 32'h3);
    apb(1'b1, `RS_OFF_CTRL, cfg(MODE_BURST, SRC_SOFT, 32'h0));
    n = n_end;
    apb(1'b1, `RS_OFF_CMD, 32'h1 << `RS_CMD_SWTRIG);
    wait_run(1'b1);
    wait_run(1'b0);
    `CHK("burst cycles", n + 3, n_end)
    $display("test burst done");
    apb(1'b1, `RS_OFF_CTRL, cfg(MODE_CONT, SRC_SOFT, 32'h0));
    wait_run(1'b1);
    n = n_end;
    repeat (5 * CYC_LEN) @(posedge clk);
    `CHK("repeats", 1'b1, running === 1'b1 && n_end >= n + 4)
    apb(1'b1, `RS_OFF_CTRL, cfg(MODE_TRIG, SRC_SOFT, 32'h0));
    wait_run(1'b0);
    $display("test continuous done");
    // Level gate on the shared pin, then on the separate gate pin
    for (int g = 0; g < 2; g++) begin
      apb(1'b1, `RS_OFF_CTRL, cfg(MODE_GATE, SRC_FRONT, 32'(g) << `RS_CTRL_INSEL));
      if (g == 1) gate <= 1'b1;
      else front <= 1'b1;
      wait_run(1'b1);
      repeat (3 * CYC_LEN + 3) @(posedge clk);
      gate <= 1'b0;
      front <= 1'b0;
      wait_run(1'b0);
      `CHK("dc hold", 1'b1, play.hold_dc)
    end
    // Edge gate toggles on each rising edge
    apb(1'b1, `RS_OFF_CTRL, cfg(MODE_GATE, SRC_FRONT, 32'h1 << `RS_CTRL_GEDGE));
    for (int t = 0; t < 2; t++) begin
      front <= 1'b1;
      repeat (4) @(posedge clk);
      front <= 1'b0;
      wait_run(t == 0);
      repeat (20) @(posedge clk);
      `CHK("gate state", t == 0, running)
    end
    $display("test gate done");
    // Self triggers: retrigger delay, then the periodic timer
    apb(1'b1, `RS_OFF_DELAY, 32'h5);
    apb(1'b1, `RS_OFF_CTRL, cfg(MODE_TRIG, SRC_RETRIG, 32'h1 << `RS_CTRL_RETRIG));
    s = n_start;
    apb(1'b1, `RS_OFF_CMD, 32'h1);
    wait_starts(s + 2);
    for (n = 0; n < 200 && n_start < s + 3; n++) @(posedge clk);
    `CHK("retrig gap", 1'b1, n >= 20 + CYC_LEN && n <= 30 + CYC_LEN)
    apb(1'b1, `RS_OFF_PERIOD, 32'h14);
    apb(1'b1, `RS_OFF_CTRL, cfg(MODE_TRIG, SRC_TIMER, 32'h0));
    wait_starts(n_start + 2);
    s = n_start;
    for (n = 0; n < 200 && n_start < s + 1; n++) @(posedge clk);
    `CHK("timer gap", 1'b1, n >= 19 && n <= 21)
    $display("test timers done");
    // Modulated idle: option one keeps playing, option two holds DC
    for (int o = 0; o < 2; o++) begin
      apb(1'b1, `RS_OFF_CTRL, cfg(MODE_TRIG, SRC_SOFT, (32'h1 << `RS_CTRL_MOD_ON) | (32'(o) << `RS_CTRL_IDLE_DC)));
      repeat (3 * CYC_LEN) @(posedge clk);
      `CHK("idle output", o == 0, running)
      s = n_mod;
      apb(1'b1, `RS_OFF_CMD, 32'h1);
      repeat (4 * CYC_LEN) @(posedge clk);
      `CHK("modulated play", s + 1, n_mod)
      `CHK("idle again", {o == 0, o == 1}, {running, play.hold_dc})
    end
    $display("test modulation done");
    give_verdict();
  end
endmodule // run_seq_bench
bind run_seq run_seq_sva u_run_seq_sva (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .play_o(play_o), .running_o(running_o));
